// ===== hdl/adc_cfg_pkg.sv
// constants, register layout and carrier types for the converter configuration block
// assumes an 8-bit special-function register port supplied by the core
package adc_cfg_pkg;
    localparam logic [7:0] ADDR_CTRL_SECOND = 8'hB2;
    localparam logic [7:0] ADDR_CONFIG = 8'hBC;
    localparam logic [7:0] ADDR_CTRL_FIRST = 8'hE8;
    localparam logic [7:0] RST_CTRL_SECOND = 8'h00;
    localparam logic [7:0] RST_CONFIG = 8'hF8;
    localparam logic [7:0] RST_CTRL_FIRST = 8'h00;
    localparam int CMB_BIT = 0;
    localparam int DIV_LSB = 3;
    localparam int DIV_W = 5;
    localparam int EIGHT_BIT = 2;
    localparam int TRACK_BIT = 1;
    localparam int GAIN_BIT = 0;
    localparam int ENABLE_BIT = 7;
    localparam int BURST_BIT = 6;
    localparam int BUSY_BIT = 4;
    localparam int TRIG_LSB = 0;
    localparam int TRIG_W = 3;
    localparam logic [2:0] DELAY_SAR_CYCLES = 3'h4;

    typedef enum logic [2:0] {
        TRIG_SOFTWARE = 3'b000,
        TRIG_TIMER0 = 3'b001,
        TRIG_TIMER2 = 3'b010,
        TRIG_TIMER3 = 3'b011,
        TRIG_EXT_PIN = 3'b100
    } trig_src_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
    } sfr_req_t;

    typedef struct packed {
        logic common_mode_buffer_on;
        logic eight_bit_resolution_on;
        logic amplifier_gain_select;
        logic burst_sequence_on;
    } analog_cfg_t;
endpackage

// ===== hdl/sar_clk_div.sv
// divides the converter input clock into one-cycle sar clock tick pulses
// assumes the selected clock source arrives as an enable on the system clock, held high when the system clock itself is the source
`timescale 1ns/1ps
module sar_clk_div
    import adc_cfg_pkg::*;
#(
    parameter int W = DIV_W
)
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // control
    input wire logic i_src_tick,
    input wire logic [W-1:0] i_div,
    input wire logic i_run,
    // result
    output logic o_sar_tick
);
    logic [W-1:0] cnt_q;

    // divide by field value plus one: tick when the count reaches the field
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n || !i_run)
            cnt_q <= '0;
        else if (i_src_tick)
            cnt_q <= (cnt_q >= i_div) ? '0 : cnt_q + 1'b1; // RQ4
    end

    assign o_sar_tick = i_run && i_src_tick && (cnt_q >= i_div); // RQ4

    a_div_period: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        o_sar_tick |=> !o_sar_tick || (i_div == '0)) // RQ4
        else $error("sar tick repeated with nonzero divider");
endmodule

// ===== hdl/adc_sar_clock_track_config.sv
// converter configuration registers, clock selection and track timing
// assumes the core drives a single-cycle sfr write strobe and reads combinationally
// Function
// RQ1: software writes zero into reserved bits 7:1 of second control register.
// RQ2: second control bit 0 turns the common mode buffer off or on.
// RQ3: software keeps buffer on when tracking time is at most 1.5 us.
// RQ4: sar clock equals converter clock divided by divider field plus one.
// RQ5: software picks divider giving fastest allowed sar clock.
// RQ6: converter clock is system clock, or fast oscillator in burst mode.
// RQ7: configuration bit 2 selects eight-bit resolution.
// RQ8: normal track starts conversion right after start-of-conversion when enabled.
// RQ9: delayed track holds tracking four sar clocks, then starts conversion.
// RQ10: configuration bit 0 selects gain half or gain one.
// RQ11: first control bit 6 enables burst mode.
// RQ12: three-bit source selects software, three timers or external pin; rest reserved.
// RQ13: delay counter counts sar ticks from trigger, cleared when disabled.
`timescale 1ns/1ps
module adc_sar_clock_track_config
    import adc_cfg_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // special-function register port
    input wire sfr_req_t i_sfr,
    output logic [7:0] o_sfr_rdata,
    output logic o_sfr_hit,
    // fast oscillator clock source as an enable on the system clock
    input wire logic i_fast_osc_tick,
    // trigger sources
    input wire logic i_timer0_ovf,
    input wire logic i_timer2_ovf,
    input wire logic i_timer3_ovf,
    input wire logic i_external_convert_pin,
    // converter controls
    output analog_cfg_t o_analog,
    output logic o_tracking,
    output logic o_convert_start,
    output logic o_sar_tick
);
    logic [7:0] ctrl2_q;
    logic [7:0] cfg_q;
    logic [7:0] ctrl1_q;
    logic pin_q;
    logic soc;
    logic sw_start;
    logic enabled;
    logic src_tick;
    logic [2:0] dly_q;
    logic tracking_q;
    logic start_q;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DELAY = 2'b01
    } trk_state_t;
    trk_state_t st_q;

    assign enabled = ctrl1_q[ENABLE_BIT];
    assign sw_start = i_sfr.wr && (i_sfr.addr == ADDR_CTRL_FIRST) && i_sfr.wdata[BUSY_BIT];

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
            ctrl2_q <= RST_CTRL_SECOND;
        else if (i_sfr.wr && i_sfr.addr == ADDR_CTRL_SECOND)
            ctrl2_q <= {7'h00, i_sfr.wdata[CMB_BIT]}; // RQ2
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
            cfg_q <= RST_CONFIG;
        else if (i_sfr.wr && i_sfr.addr == ADDR_CONFIG)
            cfg_q <= i_sfr.wdata;
    end

    // busy bit is a write-only strobe here, so it reads back as zero
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
            ctrl1_q <= RST_CTRL_FIRST;
        else if (i_sfr.wr && i_sfr.addr == ADDR_CTRL_FIRST)
            ctrl1_q <= i_sfr.wdata & 8'hC7; // RQ11
    end

    always_comb
    begin
        o_sfr_hit = 1'b1;
        case (i_sfr.addr)
            ADDR_CTRL_SECOND: o_sfr_rdata = ctrl2_q;
            ADDR_CONFIG: o_sfr_rdata = cfg_q;
            ADDR_CTRL_FIRST: o_sfr_rdata = ctrl1_q;
            default:
            begin
                o_sfr_rdata = 8'h00;
                o_sfr_hit = 1'b0;
            end
        endcase
    end

    // one driver for the whole carrier keeps strict multi-driver checks quiet
    assign o_analog = '{
        common_mode_buffer_on: ctrl2_q[CMB_BIT], // RQ2
        eight_bit_resolution_on: cfg_q[EIGHT_BIT], // RQ7
        amplifier_gain_select: cfg_q[GAIN_BIT], // RQ10
        burst_sequence_on: ctrl1_q[BURST_BIT] // RQ11
    };

    // pin is synchronous; only its rising edge counts
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
            pin_q <= 1'b0;
        else
            pin_q <= i_external_convert_pin;
    end

    always_comb
    begin
        case (ctrl1_q[TRIG_LSB +: TRIG_W]) // RQ12
            TRIG_SOFTWARE: soc = sw_start;
            TRIG_TIMER0: soc = i_timer0_ovf;
            TRIG_TIMER2: soc = i_timer2_ovf;
            TRIG_TIMER3: soc = i_timer3_ovf;
            TRIG_EXT_PIN: soc = i_external_convert_pin && !pin_q;
            default: soc = 1'b0;
        endcase
    end

    // system clock runs every edge; the oscillator arrives as an enable
    assign src_tick = ctrl1_q[BURST_BIT] ? i_fast_osc_tick : 1'b1; // RQ6

    sar_clk_div #(
        .W(DIV_W)
    ) u_div (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_src_tick(src_tick),
        .i_div(cfg_q[DIV_LSB +: DIV_W]),
        .i_run(enabled),
        .o_sar_tick(o_sar_tick)
    );

    // a trigger during the delay is ignored until conversion starts
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n || !enabled)
        begin
            st_q <= ST_IDLE;
            dly_q <= 3'h0; // RQ13
            tracking_q <= 1'b0;
            start_q <= 1'b0;
        end
        else
        begin
            start_q <= 1'b0;
            case (st_q)
                ST_IDLE:
                begin
                    tracking_q <= 1'b0;
                    if (soc && !cfg_q[TRACK_BIT])
                        start_q <= 1'b1; // RQ8
                    else if (soc)
                    begin
                        st_q <= ST_DELAY;
                        dly_q <= 3'h0; // RQ13
                        tracking_q <= 1'b1; // RQ9
                    end
                end
                ST_DELAY:
                begin
                    if (o_sar_tick && dly_q == DELAY_SAR_CYCLES - 3'h1)
                    begin
                        st_q <= ST_IDLE;
                        tracking_q <= 1'b0;
                        start_q <= 1'b1; // RQ9
                    end
                    else if (o_sar_tick)
                        dly_q <= dly_q + 3'h1; // RQ13
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    assign o_tracking = tracking_q;
    assign o_convert_start = start_q;

    a_normal_start: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (enabled && st_q == ST_IDLE && soc && !cfg_q[TRACK_BIT]) |=> o_convert_start) // RQ8
        else $error("normal track did not start next cycle");
    a_delay_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (st_q == ST_DELAY && o_convert_start) |-> 1'b0) // RQ9
        else $error("start while still delaying");
    a_delay_end: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (enabled && st_q == ST_DELAY && o_sar_tick && dly_q == 3'h3) |=> o_convert_start) // RQ9
        else $error("delayed start missing after fourth tick");
    a_counter_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !enabled |=> dly_q == 3'h0 && !o_tracking) // RQ13
        else $error("delay counter not cleared on disable");
    a_buffer_bit: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_sfr.wr && i_sfr.addr == ADDR_CTRL_SECOND)
        |=> o_analog.common_mode_buffer_on == $past(i_sfr.wdata[0]) && ctrl2_q[7:1] == 7'h00) // RQ2
        else $error("buffer bit not taken from write");
    a_gain_res: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_sfr.wr && i_sfr.addr == ADDR_CONFIG) |=> o_analog.amplifier_gain_select
        == $past(i_sfr.wdata[0]) && o_analog.eight_bit_resolution_on == $past(i_sfr.wdata[2])) // RQ7 RQ10
        else $error("gain or resolution bit wrong");
    a_burst_clock: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (ctrl1_q[BURST_BIT] && !i_fast_osc_tick) |-> !o_sar_tick) // RQ6
        else $error("sar tick without oscillator in burst mode");
    a_reserved_src: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (ctrl1_q[2:0] > 3'h4) |-> !soc) // RQ12
        else $error("reserved source produced a trigger");
    a_burst_bit: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_sfr.wr && i_sfr.addr == ADDR_CTRL_FIRST)
        |=> o_analog.burst_sequence_on == $past(i_sfr.wdata[6])) // RQ11
        else $error("burst bit not taken");

    c_normal: cover property (@(posedge i_clk_sys) o_convert_start && !cfg_q[TRACK_BIT]);
    c_delayed: cover property (@(posedge i_clk_sys) o_convert_start && cfg_q[TRACK_BIT]);
    c_pin: cover property (@(posedge i_clk_sys) ctrl1_q[2:0] == 3'h4 && soc);
    c_burst: cover property (@(posedge i_clk_sys) ctrl1_q[BURST_BIT] && o_sar_tick);
endmodule

// ===== dv/tb.sv
// self-checking bench for the converter configuration block
// assumes the sfr port is driven one request per cycle with a one-cycle write strobe
`timescale 1ns/1ps
module tb;
    import adc_cfg_pkg::*;
    logic i_clk_sys = 0;
    logic i_rst_n = 0;
    sfr_req_t i_sfr = '0;
    logic fo = 0;
    logic fo_on = 0;
    logic [3:0] tv = 4'h0;
    logic [7:0] rdata;
    logic hit, trk, cs, tick;
    analog_cfg_t ana;
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc = 0;
    int starts, ticks, srcn;
    int gaps[$];
    logic [7:0] r;
    logic [4:0] d;

    adc_sar_clock_track_config uut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_sfr(i_sfr),
        .o_sfr_rdata(rdata), .o_sfr_hit(hit), .i_fast_osc_tick(fo), .i_timer0_ovf(tv[0]),
        .i_timer2_ovf(tv[1]), .i_timer3_ovf(tv[2]), .i_external_convert_pin(tv[3]),
        .o_analog(ana), .o_tracking(trk), .o_convert_start(cs), .o_sar_tick(tick));

    initial
    begin
        forever #20 i_clk_sys = ~i_clk_sys;
    end

    // model: count start pulses, and source ticks between sar ticks while tracking
    always @(negedge i_clk_sys)
    begin
        if (cs === 1'b1) starts++;
        if (ana.burst_sequence_on !== 1'b1 || fo === 1'b1) srcn++;
        if (tick === 1'b1)
        begin
            if (trk === 1'b1) ticks++;
            if (trk === 1'b1 && ticks > 1) gaps.push_back(srcn);
            srcn = 0;
        end
    end

    always @(posedge i_clk_sys)
    begin
        if (fo_on) fo <= 1'($urandom_range(0, 1));
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] v);
        @(posedge i_clk_sys) i_sfr <= '{a, v, 1'b1};
        @(posedge i_clk_sys) i_sfr.wr <= 1'b0;
    endtask

    task automatic rd(logic [7:0] a, logic [7:0] e, logic eh);
        @(posedge i_clk_sys) i_sfr <= '{a, 8'h00, 1'b0};
        @(negedge i_clk_sys);
        chk("rdata", rdata, e);
        chk("hit", {7'h0, hit}, {7'h0, eh});
    endtask

    task automatic pulse(logic [3:0] m);
        @(posedge i_clk_sys) tv <= m;
        @(posedge i_clk_sys) tv <= 4'h0;
        repeat (12) @(posedge i_clk_sys);
    endtask

    initial
    begin
        void'($urandom(32'h7EAD));
        repeat (8) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        rd(ADDR_CTRL_SECOND, RST_CTRL_SECOND, 1'b1);
        rd(ADDR_CONFIG, RST_CONFIG, 1'b1);
        rd(ADDR_CTRL_FIRST, RST_CTRL_FIRST, 1'b1);
        rd(8'hB3, 8'h00, 1'b0);
        $display("test reset done");
        repeat (4)
        begin
            r = 8'($urandom);
            wr(ADDR_CTRL_SECOND, {7'h00, r[0]});
            rd(ADDR_CTRL_SECOND, {7'h00, r[0]}, 1'b1);
            chk("buffer", {7'h0, ana.common_mode_buffer_on}, {7'h0, r[0]});
            wr(ADDR_CONFIG, r);
            rd(ADDR_CONFIG, r, 1'b1);
            chk("eight", {7'h0, ana.eight_bit_resolution_on}, {7'h0, r[2]});
            chk("gain", {7'h0, ana.amplifier_gain_select}, {7'h0, r[0]});
            wr(ADDR_CTRL_FIRST, {1'b0, r[6], 6'h00});
            // the write lands at the edge that wr returns on, so read back after it settles
            rd(ADDR_CTRL_FIRST, {1'b0, r[6], 6'h00}, 1'b1);
            chk("burst", {7'h0, ana.burst_sequence_on}, {7'h0, r[6]});
        end
        $display("test registers done");
        // short tracking times follow, so the common mode buffer must be on
        wr(ADDR_CTRL_SECOND, 8'h01);
        wr(ADDR_CONFIG, RST_CONFIG);
        for (int s = 0; s < 6; s++)
        begin
            // foreign sources first: none of them may start a conversion
            wr(ADDR_CTRL_FIRST, 8'h80 | 8'(s));
            starts = 0;
            pulse(~(4'h0 | ((s > 0) ? 4'(1 << (s - 1)) : 4'h0)));
            chk("foreign start", 8'(starts), 8'h00);
            starts = 0;
            if (s == 0)
                wr(ADDR_CTRL_FIRST, 8'h90);
            else
                pulse((s < 5) ? 4'(1 << (s - 1)) : 4'h0);
            repeat (12) @(posedge i_clk_sys);
            chk("own start", 8'(starts), (s < 5) ? 8'h01 : 8'h00);
        end
        $display("test normal track done");
        fo_on = 1'b1;
        for (int b = 0; b < 2; b++)
        begin
            d = 5'($urandom_range(0, 3));
            wr(ADDR_CTRL_FIRST, 8'h00);
            wr(ADDR_CONFIG, {d, 3'b010});
            wr(ADDR_CTRL_FIRST, 8'h80 | 8'(b << 6));
            repeat (20) @(posedge i_clk_sys);
            ticks = 0;
            starts = 0;
            gaps.delete();
            wr(ADDR_CTRL_FIRST, 8'h90 | 8'(b << 6));
            repeat (150) @(posedge i_clk_sys);
            chk("track ticks", 8'(ticks), 8'h04);
            chk("delayed start", 8'(starts), 8'h01);
            chk("tracking end", {7'h0, trk}, 8'h00);
            foreach (gaps[i]) chk("sar period", 8'(gaps[i]), 8'(d) + 8'h01);
        end
        $display("test delayed track done");
        complete_run();
    end
endmodule
